// ==== pkg/ebi_pkg.sv ====
package ebi_pkg;

   // Bus widths and sizes.
   localparam int ADDR_W     = 24;
   localparam int DATA_W     = 32;
   localparam int NUM_BLK    = 6;
   localparam int FIFO_DEPTH = 8;
   localparam int CMD_W      = 59;

   // Register byte offsets inside the slave window.
   localparam logic [7:0] OFS_PORT_FUNC = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_XADDR     = 8'h08;
   localparam logic [7:0] OFS_XWDATA    = 8'h0c;
   localparam logic [7:0] OFS_XRCMD     = 8'h10;
   localparam logic [7:0] OFS_XRDATA    = 8'h14;
   localparam logic [7:0] OFS_BLK_BASE  = 8'h20;
   localparam logic [7:0] OFS_BLK_LAST  = 8'h34;

   // Port function register fields.
   localparam int PF_ENABLE  = 0;
   localparam int PF_VAR_LSB = 1;

   // Block configuration register fields.
   localparam int FLD_BASE_LSB  = 0;
   localparam int FLD_MASK_LSB  = 8;
   localparam int FLD_VALID     = 16;
   localparam int FLD_W16       = 17;
   localparam int FLD_WAIT_EN   = 18;
   localparam int FLD_WAIT_LSB  = 19;
   localparam int FLD_RWREC_LSB = 22;
   localparam int FLD_CSREC     = 24;

   // Values after reset.
   localparam logic [2:0]  PORT_FUNC_RST = 3'h0;
   localparam logic [31:0] BLK_CFG_RST   = 32'h0;
   localparam logic [25:0] XADDR_RST     = 26'h0;

   // Timing counts in clock cycles.
   localparam logic [3:0] STROBE_MIN_CYC = 4'h5;
   localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;
   localparam logic [1:0] RW_REC_MAX     = 2'h2;

   // Block index meaning no block matched.
   localparam logic [2:0] NO_BLK = 3'h6;

   // Transfer sizes held in the address register.
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Command word layout in the FIFO.
   localparam int CMD_WR       = 58;
   localparam int CMD_SIZE_LSB = 56;
   localparam int CMD_ADDR_LSB = 32;

   // Multiplexed pin-usage variants.
   localparam logic [1:0] VAR_A24_D8  = 2'h0;
   localparam logic [1:0] VAR_A24_D16 = 2'h1;
   localparam logic [1:0] VAR_A16_D8  = 2'h2;
   localparam logic [1:0] VAR_A8_D16  = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CSREC,
      ST_ADDR,
      ST_STROBE,
      ST_RECOV,
      ST_DONE,
      ST_GRANT
   } ext_state_type;

endpackage

// ==== pkg/stream_if.sv ====
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   // The producer drives valid and data, the consumer answers with ready.
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface

// ==== verilog/cmd_fifo.sv ====
`timescale 1ns/10ps
module cmd_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   stream_if.sink    push,
   stream_if.source  pop
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   count_r;
   logic          do_push;
   logic          do_pop;

   // Full and empty follow the true count, so ready drops only when no slot is free.
   assign push.ready = (count_r != (AW + 1)'(DEPTH));
   assign pop.valid  = (count_r != '0);
   assign pop.data   = mem_r[rd_ptr_r];
   assign do_push    = push.valid && push.ready;
   assign do_pop     = pop.valid && pop.ready;

   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge hclk) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= push.data;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ==== verilog/cs_decode.sv ====
`timescale 1ns/10ps
module cs_decode
   import ebi_pkg::*;
(
   input  wire logic [7:0]               addr_hi,
   input  wire logic [NUM_BLK-1:0][31:0] cfg,
   output logic      [2:0]               blk
);
   // Lower block numbers win when windows overlap, so scan from the top down.
   always_comb begin
      blk = NO_BLK;
      for (int i = NUM_BLK - 1; i >= 0; i--) begin
         if (cfg[i][FLD_VALID] &&
             (((addr_hi ^ cfg[i][FLD_BASE_LSB +: 8]) & ~cfg[i][FLD_MASK_LSB +: 8]) == 8'h00)) begin
            blk = 3'(i);
         end
      end
   end
endmodule

// ==== verilog/external_bus_circuit.sv ====
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module external_bus_circuit
   import ebi_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   input  wire logic        bus_mode_strap,
   input  wire logic        wait_n,
   input  wire logic        busreq,
   output logic             busack,
   output logic      [5:0]  cs_n,
   output logic             rd_n,
   output logic             wr_n,
   output logic      [1:0]  be_n,
   input  wire logic [7:0]  p0_in,
   output logic      [7:0]  p0_out,
   output logic             p0_oe_n,
   input  wire logic [7:0]  p1_in,
   output logic      [7:0]  p1_out,
   output logic             p1_oe_n,
   output logic      [7:0]  p2_out,
   output logic             p2_oe_n,
   output logic      [7:0]  p5_out,
   output logic             p5_oe_n,
   output logic      [7:0]  p6_out,
   output logic             p6_oe_n,
   output logic             p37_out,
   output logic             p37_oe_n
);
   import ebi_pkg::*;

   localparam logic [5:0] BLK_IDX0 = OFS_BLK_BASE[7:2];

   stream_if #(.W(CMD_W)) push_if ();
   stream_if #(.W(CMD_W)) pop_if ();

   logic [18:0]               sync1_r;
   logic [18:0]               sync2_r;
   logic                      strap_s, busreq_s, wait_n_s;
   logic [7:0]                p0_s, p1_s;
   logic                      mode_r, captured_r;
   logic [1:0]                settle_r;
   logic [2:0]                port_func_r;
   logic [25:0]               xaddr_r;
   logic [NUM_BLK-1:0][31:0]  blk_cfg_r;
   logic [31:0]               rdata_r;
   logic                      rvalid_r;
   logic                      dp_write_r, dp_push_r;
   logic [7:0]                dp_ofs_r;
   logic                      hreadyout_r, hresp_r;
   logic [31:0]               hrdata_r;
   logic                      ap_take, wr_fire;
   logic [31:0]               rd_val;
   logic [5:0]                blk_word;
   ext_state_type             state_r;
   logic [CMD_W-1:0]          cmd_r;
   logic [2:0]                blk_r, last_cs_r, dec_blk;
   logic                      w16_r;
   logic [1:0]                part_r, last_part_r;
   logic [3:0]                cnt_r;
   logic [31:0]               acc_r;
   logic [31:0]               cur_cfg, new_cfg;
   logic                      new_w16, port_en;
   logic [2:0]                byte_off;
   logic [5:0]                bit_off;
   logic [23:0]               part_addr;
   logic [15:0]               wd, rd_part;
   logic                      byte_hi, is_wr;
   logic [7:0]                p0_nxt, p1_nxt, p2_nxt, p5_nxt, p6_nxt;
   logic [5:0]                oe_n_nxt;
   logic [5:0]                cs_n_nxt;
   logic [1:0]                be_n_nxt;
   logic                      ale_nxt, rd_n_nxt, wr_n_nxt;
   logic [7:0]                p0_r, p1_r, p2_r, p5_r, p6_r;
   logic [5:0]                oe_n_r, cs_n_r;
   logic [1:0]                be_n_r;
   logic                      ale_r, rd_n_r, wr_n_r, busack_r;

   // Every pin input passes two flops; only the second stage is read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 19'h0;
         sync2_r <= 19'h0;
      end else begin
         sync1_r <= {bus_mode_strap, busreq, wait_n, p1_in, p0_in};
         sync2_r <= sync1_r;
      end
   end
   assign {strap_s, busreq_s, wait_n_s, p1_s, p0_s} = sync2_r;

   // The strap is taken only once both sync stages hold it, never their reset value.
   // strap capture once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         captured_r <= 1'b0;
         mode_r     <= 1'b0;
         settle_r   <= 2'h0;
      end else if (!captured_r) begin
         if (settle_r == STRAP_SETTLE_CYC) begin
            captured_r <= 1'b1;
            mode_r     <= strap_s;
         end else begin
            settle_r <= settle_r + 2'h1;
         end
      end
   end

   assign ap_take  = hsel && htrans[1] && hready;
   assign wr_fire  = dp_write_r && hreadyout_r;
   assign blk_word = haddr[7:2] - BLK_IDX0;

   // Register read decode; upper address bits are left to the fabric's select.
   always_comb begin
      rd_val = 32'h0;
      if (haddr[7:0] == OFS_PORT_FUNC) begin
         rd_val = {29'h0, port_func_r};
      end else if (haddr[7:0] == OFS_STATUS) begin
         rd_val = {26'h0, captured_r, rvalid_r, busack_r, !push_if.ready,
                   (state_r != ST_IDLE) || pop_if.valid, mode_r};
      end else if (haddr[7:0] == OFS_XADDR) begin
         rd_val = {6'h0, xaddr_r};
      end else if (haddr[7:0] == OFS_XRDATA) begin
         rd_val = rdata_r;
      end else if (haddr[7:0] >= OFS_BLK_BASE && haddr[7:0] <= OFS_BLK_LAST) begin
         rd_val = blk_cfg_r[blk_word[2:0]];
      end
   end

   // Slave handshake: pushes wait until the FIFO has room, so a full FIFO stalls the bus.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_r  <= 1'b0;
         dp_push_r   <= 1'b0;
         dp_ofs_r    <= 8'h00;
         hreadyout_r <= 1'b1;
         hrdata_r    <= 32'h0;
         hresp_r     <= 1'b0;
      end else if (ap_take) begin
         dp_write_r  <= hwrite;
         dp_ofs_r    <= haddr[7:0];
         hrdata_r    <= hwrite ? 32'h0 : rd_val;
         dp_push_r   <= hwrite && (haddr[7:0] == OFS_XWDATA || haddr[7:0] == OFS_XRCMD);
         hreadyout_r <= !(hwrite && (haddr[7:0] == OFS_XWDATA || haddr[7:0] == OFS_XRCMD));
      end else if (dp_push_r && push_if.ready) begin
         dp_push_r   <= 1'b0;
         hreadyout_r <= 1'b1;
      end else if (hreadyout_r) begin
         dp_write_r  <= 1'b0;
      end
   end

   assign push_if.valid = dp_push_r;
   assign push_if.data  = {dp_ofs_r == OFS_XWDATA, xaddr_r,
                           (dp_ofs_r == OFS_XWDATA) ? hwdata : 32'h0};

   cmd_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .hclk    (hclk),
      .hresetn (hresetn),
      .push    (push_if),
      .pop     (pop_if)
   );

   // Software registers; writes land at the end of the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_func_r <= PORT_FUNC_RST;
         xaddr_r     <= XADDR_RST;
         for (int i = 0; i < NUM_BLK; i++) begin
            blk_cfg_r[i] <= BLK_CFG_RST;
         end
      end else if (wr_fire) begin
         if (dp_ofs_r == OFS_PORT_FUNC) begin
            port_func_r <= hwdata[2:0];
         end else if (dp_ofs_r == OFS_XADDR) begin
            xaddr_r <= hwdata[25:0];
         end else if (dp_ofs_r >= OFS_BLK_BASE && dp_ofs_r <= OFS_BLK_LAST) begin
            blk_cfg_r[3'(dp_ofs_r[7:2] - BLK_IDX0)] <= hwdata;
         end
      end
   end

   cs_decode u_cs (
      .addr_hi (pop_if.data[CMD_ADDR_LSB + 16 +: 8]),
      .cfg     (blk_cfg_r),
      .blk     (dec_blk)
   );

   assign port_en = port_func_r[PF_ENABLE];
   assign new_cfg = (dec_blk == NO_BLK) ? BLK_CFG_RST : blk_cfg_r[dec_blk];
   assign cur_cfg = (blk_r == NO_BLK) ? BLK_CFG_RST : blk_cfg_r[blk_r];
   assign new_w16 = new_cfg[FLD_W16] && (!mode_r || port_func_r[PF_VAR_LSB +: 2] == VAR_A24_D16
                                         || port_func_r[PF_VAR_LSB +: 2] == VAR_A8_D16);
   assign pop_if.ready = (state_r == ST_IDLE) && !busreq_s && port_en;

   // Per-part address and data lanes.
   assign is_wr     = cmd_r[CMD_WR];
   assign byte_off  = w16_r ? {part_r, 1'b0} : {1'b0, part_r};
   assign bit_off   = {byte_off, 3'b000};
   assign part_addr = cmd_r[CMD_ADDR_LSB +: 24] + {21'h0, byte_off};
   assign byte_hi   = w16_r && part_addr[0] && (cmd_r[CMD_SIZE_LSB +: 2] == SIZE_BYTE);
   assign wd        = byte_hi ? {cmd_r[7:0], 8'h00} : 16'(cmd_r[31:0] >> bit_off);
   assign rd_part   = byte_hi ? {8'h00, p1_s} : (w16_r ? {p1_s, p0_s} : {8'h00, p0_s});

   // Bus cycle sequencer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r     <= ST_IDLE;
         cmd_r       <= '0;
         blk_r       <= NO_BLK;
         last_cs_r   <= NO_BLK;
         w16_r       <= 1'b0;
         part_r      <= 2'h0;
         last_part_r <= 2'h0;
         cnt_r       <= 4'h0;
         acc_r       <= 32'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (busreq_s) begin
                  state_r <= ST_GRANT;
               end else if (pop_if.valid && pop_if.ready) begin
                  cmd_r     <= pop_if.data;
                  blk_r     <= dec_blk;
                  last_cs_r <= dec_blk;
                  w16_r     <= new_w16;
                  part_r    <= 2'h0;
                  acc_r     <= 32'h0;
                  case (pop_if.data[CMD_SIZE_LSB +: 2])
                     SIZE_HALF: last_part_r <= new_w16 ? 2'h0 : 2'h1;
                     SIZE_WORD: last_part_r <= new_w16 ? 2'h1 : 2'h3;
                     default:   last_part_r <= 2'h0;
                  endcase
                  if (dec_blk != last_cs_r && new_cfg[FLD_CSREC]) begin
                     state_r <= ST_CSREC;
                  end else begin
                     state_r <= ST_ADDR;
                  end
               end
            end
            ST_CSREC: begin
               state_r <= ST_ADDR;
            end
            ST_ADDR: begin
               cnt_r   <= STROBE_MIN_CYC - 4'h1 +
                          (cur_cfg[FLD_WAIT_EN] ? {1'b0, cur_cfg[FLD_WAIT_LSB +: 3]} : 4'h0);
               state_r <= ST_STROBE;
            end
            ST_STROBE: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (wait_n_s) begin
                  acc_r <= acc_r | ({16'h0, rd_part} << bit_off);
                  if (cur_cfg[FLD_RWREC_LSB +: 2] != 2'h0) begin
                     cnt_r   <= {2'h0, (cur_cfg[FLD_RWREC_LSB +: 2] > RW_REC_MAX) ?
                                       RW_REC_MAX : cur_cfg[FLD_RWREC_LSB +: 2]};
                     state_r <= ST_RECOV;
                  end else if (part_r != last_part_r) begin
                     part_r  <= part_r + 2'h1;
                     state_r <= ST_ADDR;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_RECOV: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  if (part_r != last_part_r) begin
                     part_r  <= part_r + 2'h1;
                     state_r <= ST_ADDR;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            ST_GRANT: begin
               if (!busreq_s) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Read result; a completing read wins over a clearing read of the data register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r  <= 32'h0;
         rvalid_r <= 1'b0;
      end else if (state_r == ST_DONE && !is_wr) begin
         rdata_r  <= acc_r;
         rvalid_r <= 1'b1;
      end else if (ap_take && !hwrite && haddr[7:0] == OFS_XRDATA) begin
         rvalid_r <= 1'b0;
      end
   end

   // Pin values for the next cycle; every released pin has its enable high.
   always_comb begin
      p0_nxt   = 8'h00;
      p1_nxt   = 8'h00;
      p2_nxt   = part_addr[23:16];
      p5_nxt   = part_addr[7:0];
      p6_nxt   = part_addr[15:8];
      oe_n_nxt = 6'h3f;
      ale_nxt  = 1'b0;
      cs_n_nxt = 6'h3f;
      rd_n_nxt = 1'b1;
      wr_n_nxt = 1'b1;
      be_n_nxt = 2'h3;
      if (port_en && state_r != ST_GRANT) begin
         if (!mode_r) begin
            p0_nxt      = wd[7:0];
            p1_nxt      = wd[15:8];
            oe_n_nxt[0] = !(state_r == ST_STROBE && is_wr);
            oe_n_nxt[1] = !(state_r == ST_STROBE && is_wr && w16_r);
            if (state_r == ST_ADDR || state_r == ST_STROBE || state_r == ST_RECOV) begin
               oe_n_nxt[2] = 1'b0;
               oe_n_nxt[3] = 1'b0;
               oe_n_nxt[4] = 1'b0;
            end
         end else begin
            oe_n_nxt[5] = 1'b0;
            ale_nxt     = (state_r == ST_ADDR);
            p0_nxt      = (state_r == ST_ADDR) ? part_addr[7:0] : wd[7:0];
            oe_n_nxt[0] = !(state_r == ST_ADDR || (state_r == ST_STROBE && is_wr));
            case (port_func_r[PF_VAR_LSB +: 2])
               VAR_A24_D16: begin
                  p1_nxt      = (state_r == ST_ADDR) ? part_addr[15:8] : wd[15:8];
                  oe_n_nxt[1] = !(state_r == ST_ADDR || (state_r == ST_STROBE && is_wr && w16_r));
               end
               VAR_A8_D16: begin
                  p1_nxt      = wd[15:8];
                  oe_n_nxt[1] = !(state_r == ST_STROBE && is_wr && w16_r);
               end
               default: begin
                  p1_nxt      = part_addr[15:8];
                  oe_n_nxt[1] = !(state_r == ST_ADDR || state_r == ST_STROBE ||
                                  state_r == ST_RECOV);
               end
            endcase
            if (port_func_r[PF_VAR_LSB +: 2] == VAR_A24_D8 ||
                port_func_r[PF_VAR_LSB +: 2] == VAR_A24_D16) begin
               oe_n_nxt[2] = !(state_r == ST_ADDR || state_r == ST_STROBE ||
                               state_r == ST_RECOV);
            end
         end
         if ((state_r == ST_ADDR || state_r == ST_STROBE) && blk_r != NO_BLK) begin
            cs_n_nxt[blk_r] = 1'b0;
         end
         if (state_r == ST_STROBE) begin
            rd_n_nxt = is_wr;
            wr_n_nxt = !is_wr;
            be_n_nxt = byte_hi ? 2'h1 :
                       ((w16_r && cmd_r[CMD_SIZE_LSB +: 2] != SIZE_BYTE) ? 2'h0 : 2'h2);
         end
      end
   end

   // Output flops; all bus pins sit released after reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p0_r     <= 8'h00;
         p1_r     <= 8'h00;
         p2_r     <= 8'h00;
         p5_r     <= 8'h00;
         p6_r     <= 8'h00;
         oe_n_r   <= 6'h3f;
         ale_r    <= 1'b0;
         cs_n_r   <= 6'h3f;
         rd_n_r   <= 1'b1;
         wr_n_r   <= 1'b1;
         be_n_r   <= 2'h3;
         busack_r <= 1'b0;
      end else begin
         p0_r     <= p0_nxt;
         p1_r     <= p1_nxt;
         p2_r     <= p2_nxt;
         p5_r     <= p5_nxt;
         p6_r     <= p6_nxt;
         oe_n_r   <= oe_n_nxt;
         ale_r    <= ale_nxt;
         cs_n_r   <= cs_n_nxt;
         rd_n_r   <= rd_n_nxt;
         wr_n_r   <= wr_n_nxt;
         be_n_r   <= be_n_nxt;
         busack_r <= (state_r == ST_GRANT);
      end
   end

   assign hreadyout = hreadyout_r;
   assign hrdata    = hrdata_r;
   assign hresp     = hresp_r;
   assign busack    = busack_r;
   assign cs_n      = cs_n_r;
   assign rd_n      = rd_n_r;
   assign wr_n      = wr_n_r;
   assign be_n      = be_n_r;
   assign p0_out    = p0_r;
   assign p0_oe_n   = oe_n_r[0];
   assign p1_out    = p1_r;
   assign p1_oe_n   = oe_n_r[1];
   assign p2_out    = p2_r;
   assign p2_oe_n   = oe_n_r[2];
   assign p5_out    = p5_r;
   assign p5_oe_n   = oe_n_r[3];
   assign p6_out    = p6_r;
   assign p6_oe_n   = oe_n_r[4];
   assign p37_out   = ale_r;
   assign p37_oe_n  = oe_n_r[5];
endmodule

// ==== dv/ebi_chk.sv ====
`timescale 1ns/10ps
module ebi_chk (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       bus_mode_strap,
   input wire logic       busack,
   input wire logic [5:0] cs_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       p0_oe_n,
   input wire logic       p37_oe_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Pin relations that must hold on every external cycle.
   a_one_cs: assert property ($onehot0(~cs_n)) else $error("two selects");
   a_rd_len: assert property ($fell(rd_n) |-> !rd_n [*5]) else $error("short read");
   a_one_strobe: assert property (rd_n || wr_n) else $error("both strobes");
   a_grant_idle: assert property (busack |-> cs_n == 6'h3f && rd_n && wr_n)
      else $error("pins busy in grant");
   a_strobe_cs: assert property (!(rd_n && wr_n) |-> cs_n != 6'h3f)
      else $error("strobe without select");
   a_rd_free: assert property (!rd_n |-> p0_oe_n) else $error("data driven on read");
   a_wr_drive: assert property (!wr_n |-> !p0_oe_n) else $error("data idle on write");
   a_sep_gpio: assert property (!bus_mode_strap |-> p37_oe_n) else $error("latch on");
endmodule
bind external_bus_circuit ebi_chk u_chk (.hclk, .hresetn, .bus_mode_strap, .busack,
   .cs_n, .rd_n, .wr_n, .p0_oe_n, .p37_oe_n);

// ==== dv/ebi_mem.sv ====
`timescale 1ns/10ps
module ebi_mem (
   input wire logic       hclk,
   input wire logic       cs0_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       slow,
   input wire logic       mux,
   input wire logic       ale,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic     [7:0] rdata,
   output logic           wait_n
);
   logic [7:0] mem [256];
   logic [2:0] cnt = 3'h0;
   logic [7:0] la = 8'h00;
   logic [7:0] ma;
   // The low address is latched from the shared lines while ale is high.
   always @(posedge hclk) if (ale) la <= wdata;
   assign ma = mux ? la : addr;
   // Byte store on the low lane, written while the strobe is low.
   always @(posedge hclk) if (!cs0_n && !wr_n) mem[ma] <= wdata;
   // A slow device holds the cycle for the first four clocks of each strobe.
   always @(posedge hclk) cnt <= (rd_n && wr_n) ? {slow, 2'h0} : cnt - {2'h0, cnt != 3'h0};
   assign wait_n = (cnt == 3'h0);
   // Released lines show the inverse so a stale value cannot pass.
   assign rdata = (!cs0_n && !rd_n) ? mem[ma] : ~mem[ma];
endmodule

// ==== dv/external_bus_circuit_tb_top.sv ====
`timescale 1ns/10ps
module external_bus_circuit_tb_top;
   import ebi_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, busreq = 0, slow = 0, strap = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0;
   logic        hreadyout, busack, rd_n, wr_n, wait_n, hresp, ale;
   logic [7:0]  p0_out, p5_out, mrd;
   logic [5:0]  cs_n;
   int          mismatches = 0, n_checks = 0, a, exp[256], aq[$];
   initial forever #10 hclk = ~hclk;
   external_bus_circuit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .bus_mode_strap(strap), .wait_n, .busreq, .busack, .cs_n, .rd_n, .wr_n, .be_n(),
      .p0_in(mrd), .p0_out, .p0_oe_n(), .p1_in(8'h00), .p1_out(), .p1_oe_n(), .p2_out(),
      .p2_oe_n(), .p5_out, .p5_oe_n(), .p6_out(), .p6_oe_n(), .p37_out(ale), .p37_oe_n());
   ebi_mem u_mem (.hclk, .cs0_n(cs_n[0]), .rd_n, .wr_n, .slow, .mux(strap), .ale,
      .addr(p5_out),
      .wdata(p0_out), .rdata(mrd), .wait_n);
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Wait up to a bounded count for the slave to take the current phase.
   task automatic hwait;
      int n;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 999);
      if (hreadyout !== 1'b1) begin mismatches++; stop_test; end
   endtask
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, ad}; hwrite <= w;
      hwait;
      htrans <= 2'h0; hwdata <= d;
      hwait;
      q = hrdata;
   endtask
   task automatic rd_ext(input int ea);
      int n;
      ahb(1'b1, OFS_XADDR, ea);
      ahb(1'b1, OFS_XRCMD, 0);
      n = 0;
      do begin ahb(1'b0, OFS_STATUS, 0); n++; end while (q[4] !== 1'b1 && n < 200);
      if (q[4] !== 1'b1) begin mismatches++; stop_test; end
      ahb(1'b0, OFS_XRDATA, 0);
      chk(q[7:0], exp[ea][7:0]);
      chk(hresp, 1'b0);
   endtask
   initial begin
      void'($urandom(39592));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, OFS_PORT_FUNC, 0); chk(q, 0);
      ahb(1'b0, 8'h40, 0); chk(q, 0);
      $display("test reset done");
      // Block 0 covers the low window, 8-bit, with random waits and recovery.
      ahb(1'b1, OFS_BLK_BASE, (32'h1 << FLD_VALID) | ($urandom & 32'h01fc_0000));
      ahb(1'b1, OFS_PORT_FUNC, 1);
      for (int i = 0; i < 12; i++) begin
         slow <= (i < 9);
         a = $urandom % 256;
         exp[a] = $urandom % 256;
         aq.push_back(a);
         ahb(1'b1, OFS_XADDR, a);
         ahb(1'b1, OFS_XWDATA, exp[a]);
      end
      foreach (aq[i]) rd_ext(aq[i]);
      $display("test write read done");
      busreq <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(busack, 1'b1);
      busreq <= 1'b0;
      repeat (20) @(posedge hclk);
      chk(busack, 1'b0);
      rd_ext(aq[0]);
      $display("test arbitration done");
      // A second reset with the strap high brings the shared address/data bus up.
      hresetn <= 1'b0;
      strap <= 1'b1;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, OFS_PORT_FUNC, 0);
      chk(q, 0);
      ahb(1'b1, OFS_BLK_BASE, (32'h1 << FLD_VALID) | ($urandom & 32'h01fc_0000));
      ahb(1'b1, OFS_PORT_FUNC, 32'({VAR_A24_D8, 1'b1}));
      ahb(1'b0, OFS_STATUS, 0);
      chk(q[0], 1'b1);
      a = $urandom % 256;
      exp[a] = $urandom % 256;
      ahb(1'b1, OFS_XADDR, a);
      ahb(1'b1, OFS_XWDATA, exp[a]);
      rd_ext(a);
      rd_ext(aq[1]);
      $display("test multiplexed done");
      stop_test;
   end
endmodule
